// ### core/sacs_cfg.svh
// constants of the conversion sequencer: edge numbers, widths, oscillator timing
// assumes one system clock; edges are counted on the clock-pin input clock, or on the oscillator in self-clock mode
// Behaviour
// - busy low during conversion, high after
// - internal clock is the input clock (clock pin, or oscillator in self-clock mode) divided by two
// - conversion lasts 20 input clock cycles
// - hold on third falling input clock edge
// - three input cycles before first comparison
// - track/hold tracks while idle
// - approximation register reset in first internal pulse
// - self-clocked oscillator stops at completion
// - external clock gated off after completion
// - bipolar result is offset binary
// - read within one clock of done: no conversion
// - read during conversion returns previous result
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH

`define SACS_CODE_W       8
`define SACS_CNT_W        5
`define SACS_SYNC_W       5
`define SACS_SYNC_IDLE    5'h03
`define SACS_EDGE_RESET   5'h01
`define SACS_EDGE_TRIAL   5'h02
`define SACS_EDGE_HOLD    5'h03
`define SACS_EDGE_CMP0    5'h04
`define SACS_EDGE_CMPN    5'h12
`define SACS_EDGE_LAST    5'h14
`define SACS_CODE_ZERO    8'h00
`define SACS_CODE_MSB     8'h80
`define SACS_CNT_ZERO     5'h00
`define SACS_CNT_ONE      5'h01
`define SACS_CLK_PERIOD_NS 8
`define SACS_OSC_PERIOD_NS 250
`define SACS_OSC_HALF     (((`SACS_OSC_PERIOD_NS) / 2) / (`SACS_CLK_PERIOD_NS))
`define SACS_OSC_HALF_M1  5'((`SACS_OSC_HALF) - 1)
`define SACS_OSC_PERIOD_M1 5'((2 * (`SACS_OSC_HALF)) - 1)

`endif

// ### core/sacs_pkg.sv
// types shared by the conversion sequencer files
// assumes sacs_cfg.svh gives the widths
`include "sacs_cfg.svh"
package sacs_pkg;
   typedef enum logic {SACS_IDLE, SACS_CONVERT} sacs_state_t;
   typedef logic [`SACS_CODE_W-1:0] sacs_code_t;
endpackage : sacs_pkg

// ### core/sacs_result_reg.sv
// latched output register holding the last completed result
// assumes a load pulse from the sequencer on the system clock
`timescale 1ns/1ns
`include "sacs_cfg.svh"
module sacs_result_reg (
   input  wire logic                clock,
   input  wire logic                nrst,
   input  wire logic                load,
   input  wire sacs_pkg::sacs_code_t d,
   output sacs_pkg::sacs_code_t      q
);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         q <= `SACS_CODE_ZERO;
      end else if (load) begin
         q <= d;
      end
   end
endmodule : sacs_result_reg

// ### core/sacs_seq.sv
// successive-approximation conversion sequencer with track/hold control
// assumes pins cs_n, rd_n, clk_pin, self_clock and cmp_in are asynchronous;
// the comparator output cmp_in is high when the held input is at or above dac_code
`timescale 1ns/1ns
`include "sacs_cfg.svh"
module sacs_seq (
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic                 cs_n,
   input  wire logic                 rd_n,
   input  wire logic                 clk_pin,
   input  wire logic                 self_clock,
   input  wire logic                 cmp_in,
   output logic                      busy_n,
   output logic                      hold,
   output sacs_pkg::sacs_code_t      dac_code,
   output sacs_pkg::sacs_code_t      data_out,
   output logic                      data_oe,
   output logic                      osc_run,
   output logic                      int_clk
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [`SACS_SYNC_W-1:0] sync1;
   logic [`SACS_SYNC_W-1:0] sync2;
   wire  [`SACS_SYNC_W-1:0] raw_in = {cmp_in, self_clock, clk_pin, rd_n, cs_n};

   always_ff @(posedge clock) begin
      // strobes reset to their idle high level: no false select edge after reset
      if (!nrst) begin
         sync1 <= `SACS_SYNC_IDLE;
         sync2 <= `SACS_SYNC_IDLE;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   // ****************************************
   // decode
   // ****************************************
   sacs_pkg::sacs_state_t    state;
   logic                     sel_d;
   logic                     clkp_d;
   logic                     grace;
   logic [`SACS_CNT_W-1:0]   edge_cnt;
   logic [`SACS_CNT_W-1:0]   osc_cnt;
   logic                     osc_lvl;
   logic [`SACS_CNT_W-1:0]   grace_cnt;
   sacs_pkg::sacs_code_t     successive_approx_register;
   sacs_pkg::sacs_code_t     mask;

   wire sel        = ~sync2[0] & ~sync2[1];
   wire clkp       = sync2[2];
   wire self_mode  = sync2[3];
   wire cmp        = sync2[4];
   wire converting = (state == sacs_pkg::SACS_CONVERT);
   wire ext_fall   = clkp_d & ~clkp;
   wire osc_wrap   = (osc_cnt == `SACS_OSC_HALF_M1);
   wire osc_fall   = osc_run & osc_lvl & osc_wrap;
   wire in_fall    = self_mode ? osc_fall : ext_fall;
   wire step       = converting & in_fall;
   wire [`SACS_CNT_W-1:0] next_cnt = edge_cnt + `SACS_CNT_ONE;
   // a select that is already low does not restart; only its falling edge counts
   wire start      = sel & ~sel_d & ~converting & ~grace;
   wire done       = step & (next_cnt == `SACS_EDGE_LAST);
   wire decide     = step & ~next_cnt[0] & (next_cnt >= `SACS_EDGE_CMP0)
                     & (next_cnt <= `SACS_EDGE_CMPN);
   // oscillator is stopped in the window, so self mode counts one period itself
   wire grace_end  = self_mode ? (grace_cnt == `SACS_OSC_PERIOD_M1) : ext_fall;
   wire sacs_pkg::sacs_code_t next_sar = (cmp ? successive_approx_register : (successive_approx_register & ~mask)) | (mask >> 1);

   // oscillator runs only for a conversion and its start cycle; it is stopped in the read window after it
   assign osc_run = self_mode & (converting | start);
   assign busy_n  = ~converting;
   assign dac_code = successive_approx_register;
   // three-state enable follows the strobes; mid-conversion reads show old data
   assign data_oe = sel;

   // ****************************************
   // clocks and sequencing
   // ****************************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sel_d   <= 1'b0;
         clkp_d  <= 1'b0;
         osc_cnt <= `SACS_CNT_ZERO;
         osc_lvl <= 1'b0;
      end else begin
         sel_d  <= sel;
         clkp_d <= clkp;
         if (!osc_run) begin
            osc_cnt <= `SACS_CNT_ZERO;
            osc_lvl <= 1'b0;
         end else if (osc_wrap) begin
            osc_cnt <= `SACS_CNT_ZERO;
            osc_lvl <= ~osc_lvl;
         end else begin
            osc_cnt <= osc_cnt + `SACS_CNT_ONE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state    <= sacs_pkg::SACS_IDLE;
         edge_cnt <= `SACS_CNT_ZERO;
         int_clk  <= 1'b0;
         hold     <= 1'b0;
      end else begin
         case (state)
            sacs_pkg::SACS_IDLE: begin
               hold    <= 1'b0;
               int_clk <= 1'b0;
               if (start) begin
                  state    <= sacs_pkg::SACS_CONVERT;
                  edge_cnt <= `SACS_CNT_ZERO;
               end
            end
            sacs_pkg::SACS_CONVERT: begin
               if (step) begin
                  edge_cnt <= next_cnt;
                  int_clk  <= ~int_clk;
                  if (next_cnt == `SACS_EDGE_HOLD) begin
                     hold <= 1'b1;
                  end
               end
               if (done) begin
                  state   <= sacs_pkg::SACS_IDLE;
                  hold    <= 1'b0;
                  int_clk <= 1'b0;
               end
            end
            default: begin
               state <= sacs_pkg::SACS_IDLE;
            end
         endcase
      end
   end

   // read window after completion: a read here only fetches data
   always_ff @(posedge clock) begin
      if (!nrst) begin
         grace     <= 1'b0;
         grace_cnt <= `SACS_CNT_ZERO;
      end else if (done) begin
         grace     <= 1'b1;
         grace_cnt <= `SACS_CNT_ZERO;
      end else if (grace) begin
         grace     <= ~grace_end;
         grace_cnt <= grace_cnt + `SACS_CNT_ONE;
      end
   end

   // ****************************************
   // approximation register
   // ****************************************
   // result code is straight binary; with the bipolar input scaling it is offset binary
   always_ff @(posedge clock) begin
      if (!nrst) begin
         successive_approx_register  <= `SACS_CODE_ZERO;
         mask <= `SACS_CODE_ZERO;
      end else if (step && next_cnt == `SACS_EDGE_RESET) begin
         successive_approx_register  <= `SACS_CODE_ZERO;
         mask <= `SACS_CODE_ZERO;
      end else if (step && next_cnt == `SACS_EDGE_TRIAL) begin
         successive_approx_register  <= `SACS_CODE_MSB;
         mask <= `SACS_CODE_MSB;
      end else if (decide) begin
         successive_approx_register  <= next_sar;
         mask <= mask >> 1;
      end
   end

   sacs_result_reg u_result (
      .clock (clock),
      .nrst  (nrst),
      .load  (done),
      .d     (successive_approx_register),
      .q     (data_out)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   busy_start_a: assert property (start |=> !busy_n)
      else $error("busy not low after start");
   busy_done_a: assert property (done |=> busy_n
                                 && $past(edge_cnt) == (`SACS_EDGE_LAST - `SACS_CNT_ONE))
      else $error("conversion end at wrong edge");
   hold_edge_a: assert property (step && next_cnt == `SACS_EDGE_HOLD |=> hold)
      else $error("hold not taken on third edge");
   hold_early_a: assert property (converting && edge_cnt < `SACS_EDGE_HOLD |-> !hold)
      else $error("hold before third edge");
   track_idle_a: assert property (!converting |-> !hold)
      else $error("hold while idle");
   sar_reset_a: assert property (step && next_cnt == `SACS_EDGE_RESET |=> successive_approx_register == 8'h00)
      else $error("register not reset on first pulse");
   no_early_cmp_a: assert property (converting && edge_cnt >= `SACS_EDGE_RESET
                                    && edge_cnt < `SACS_EDGE_CMP0
                                    |-> (successive_approx_register == `SACS_CODE_ZERO || successive_approx_register == `SACS_CODE_MSB))
      else $error("decision before compare mode");
   osc_stop_a: assert property (done |=> !osc_run)
      else $error("oscillator still running after completion");
   clk_gate_a: assert property (!converting |-> !int_clk)
      else $error("internal clock runs while idle");
   divide_a: assert property (step |=> int_clk != $past(int_clk))
      else $error("internal clock did not toggle");
   latch_a: assert property (done |=> data_out == $past(successive_approx_register))
      else $error("result not latched");
   grace_read_a: assert property (grace && sel |=> busy_n)
      else $error("conversion started in read window");
   old_data_a: assert property (converting && !done |=> $stable(data_out))
      else $error("output changed mid conversion");

   start_c: cover property (start);
   full_conv_c: cover property (done);
   grace_read_c: cover property (grace && sel);
   busy_read_c: cover property (converting && sel && !sel_d);
endmodule : sacs_seq

// ### verification/sacs_host_model.sv
// host bus model: select and read strobes of the converter
// assumes the bench moves req only at falling clock edges
`timescale 1ns/1ns
module sacs_host_model (
   input  wire logic clock,
   input  wire logic req,
   output logic      cs_n,
   output logic      rd_n
);
   logic             req_q;
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      req_q = 1'b0;
   end
   // req taken on the rising edge, so the bench's falling-edge update cannot race it
   always @(posedge clock) req_q <= req;
   // both strobes move together, never one alone
   always @(negedge clock) begin
      cs_n <= ~req_q;
      rd_n <= ~req_q;
   end
endmodule : sacs_host_model

// ### verification/tb.sv
// self-checking bench for the conversion sequencer
// assumes sacs_host_model drives the strobes; clock pin made here
`timescale 1ns/1ns
module tb;
   logic                 clock, nrst, req, clk_pin, self_clock, cmp_in, ic_q;
   logic                 cs_n, rd_n, busy_n, hold, data_oe, osc_run, int_clk;
   sacs_pkg::sacs_code_t dac_code, data_out, tgt, prev;
   int                   seed = 84009;
   int                   err_total, compares, fcnt, ir, n0, k;

   sacs_seq dut (.clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
      .clk_pin(clk_pin), .self_clock(self_clock), .cmp_in(cmp_in),
      .busy_n(busy_n), .hold(hold), .dac_code(dac_code), .data_out(data_out),
      .data_oe(data_oe), .osc_run(osc_run), .int_clk(int_clk));
   sacs_host_model host (.clock(clock), .req(req), .cs_n(cs_n), .rd_n(rd_n));

   // ****************
   // clocks and comparator
   // ****************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // even duty, slightly under 4 MHz: free running between frames
   initial begin
      clk_pin = 1'b0;
      fcnt = 0;
      forever begin
         repeat (16) @(negedge clock);
         clk_pin = ~clk_pin;
         if (!clk_pin) fcnt++;
      end
   end
   always @(negedge clock) cmp_in <= (tgt >= dac_code);
   always @(posedge clock) begin
      ic_q <= int_clk;
      if (int_clk === 1'b1 && ic_q === 1'b0) ir <= ir + 1;
   end

   // ****************
   // checks and expectations
   // ****************
   function automatic sacs_pkg::sacs_code_t sar_of(input sacs_pkg::sacs_code_t t);
      sacs_pkg::sacs_code_t c;
      c = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         c[b] = 1'b1;
         if (t < c) c[b] = 1'b0;
      end
      return c;
   endfunction : sar_of
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_cnt(input string nm, input int e, input int g);
      compares++;
      if (g != e) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_cnt
   task automatic report_and_stop;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   // slow-memory read: select held through the conversion
   task automatic conv(input logic [7:0] t, input logic s);
      @(negedge clock);
      self_clock = s;
      tgt = t;
      @(negedge clk_pin);
      repeat (5) @(negedge clock);
      ir = 0;
      n0 = fcnt;
      req = 1'b1;
      wait (int_clk === 1'b1);
      @(negedge clock);
      chk("sar_clear", 8'h00, dac_code);
      wait (hold === 1'b1);
      @(negedge clock);
      if (!s) chk_cnt("hold_edge", 3, fcnt - n0);
      chk("first_trial", 8'h80, dac_code);
      chk("old_data", prev, data_out);
      chk("data_oe", 8'h01, {7'h00, data_oe});
      chk("osc_run", {7'h00, s}, {7'h00, osc_run});
      chk("busy_low", 8'h00, {7'h00, busy_n});
      wait (busy_n === 1'b1);
      @(negedge clock);
      if (!s) chk_cnt("conv_edges", 20, fcnt - n0);
      chk_cnt("int_pulses", 10, ir);
      chk("result", sar_of(t), data_out);
      prev = sar_of(t);
      req = 1'b0;
      repeat (2) @(negedge clock);
      req = 1'b1;
      // quick reselect must only read; clocks stay gated meanwhile
      for (k = 0; k < 60; k++) begin
         @(negedge clock);
         if (busy_n !== 1'b1 || int_clk !== 1'b0 || hold !== 1'b0 || osc_run !== 1'b0) break;
      end
      chk_cnt("idle_span", 60, k);
      req = 1'b0;
   endtask : conv

   // ****************
   // main sequence and watchdog
   // ****************
   initial begin
      nrst = 1'b0;
      req = 1'b0;
      self_clock = 1'b0;
      cmp_in = 1'b0;
      tgt = 8'h00;
      prev = 8'h00;
      ir = 0;
      err_total = 0;
      compares = 0;
      repeat (20) @(negedge clock);
      nrst = 1'b1;
      chk("busy_rst", 8'h01, {7'h00, busy_n});
      repeat (4) @(negedge clock);
      chk("busy_idle", 8'h01, {7'h00, busy_n});
      conv(8'hff, 1'b0);
      conv(8'h00, 1'b1);
      conv(8'h80, 1'b0);
      conv(8'h7f, 1'b1);
      // second reset in mid-run: result and register clear, no false start
      nrst = 1'b0;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      chk("data_rst", 8'h00, data_out);
      chk("dac_rst", 8'h00, dac_code);
      repeat (4) @(negedge clock);
      chk("busy_idle2", 8'h01, {7'h00, busy_n});
      prev = 8'h00;
      conv(8'h5a, 1'b1);
      conv(8'ha5, 1'b1);
      for (int i = 0; i < 8; i++) conv(8'($random(seed)), 1'($random(seed)));
      report_and_stop();
   end
   // fourteen frames take about ten thousand cycles
   initial begin
      repeat (30000) @(posedge clock);
      err_total++;
      report_and_stop();
   end
endmodule : tb
